// *** logic/uart_ext_pkg.sv ***
// Constants and types shared by the channel register decoder and the infrared decoder.
// Assumes APB with 32-bit data; each register index occupies one aligned word.
package uart_ext_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_DATA     = 3'h0;
    localparam logic [2:0] IDX_IER      = 3'h1;
    localparam logic [2:0] IDX_FEAT     = 3'h2;
    localparam logic [2:0] IDX_LCR      = 3'h3;
    localparam logic [2:0] IDX_MCR      = 3'h4;
    localparam logic [2:0] IDX_LSR      = 3'h5;
    localparam logic [2:0] IDX_MSR      = 3'h6;
    localparam logic [2:0] IDX_SCR      = 3'h7;
    localparam int         IDX_LSB      = 2;

    // Access-select values and bit positions
    localparam logic [7:0] LCR_EXT_KEY  = 8'hBF;
    localparam int         LCR_DIV_BIT  = 7;
    localparam int         FEAT_EXT_BIT = 4;
    localparam int         MCR_EXT_BIT  = 6;

    // Values after reset
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] RST_LCR      = 8'h00;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // Infrared bit period in sampling ticks
    localparam int         IR_BIT_TICKS = 16;
    localparam logic [3:0] IR_LAST_TICK = 4'(IR_BIT_TICKS - 1);
    // Cycles after reset until the edge detector holds real pin samples
    localparam logic [1:0] IR_WARM_DONE = 2'h3;

    typedef enum logic [3:0] {
        SEL_DATA   = 4'h0,
        SEL_IER    = 4'h1,
        SEL_IDENT  = 4'h2,
        SEL_LCR    = 4'h3,
        SEL_MCR    = 4'h4,
        SEL_LSR    = 4'h5,
        SEL_MSR    = 4'h6,
        SEL_SCR    = 4'h7,
        SEL_DIV_LO = 4'h8,
        SEL_DIV_HI = 4'h9,
        SEL_FEAT   = 4'hA,
        SEL_RESUME_CHAR_FIRST   = 4'hB,
        SEL_RESUME_CHAR_SECOND   = 4'hC,
        SEL_PAUSE_CHAR_FIRST  = 4'hD,
        SEL_PAUSE_CHAR_SECOND  = 4'hE,
        SEL_TCR    = 4'hF
    } sel_t;

endpackage

// *** logic/ir_rx_decoder.sv ***
// Infrared receive pulse decoder: turns each falling edge on the pin into a 16-tick zero.
// Assumes a one-cycle sampling tick at sixteen times the baud rate on the system clock.
`timescale 1ns/1ps
module ir_rx_decoder (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic tick_i,
    input  wire logic ir_rx_i,
    output logic      int_rx_o
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic       pend;
        logic       int_rx;
        logic [3:0] cnt;
        logic [1:0] warm;
    } dec_t;

    dec_t q, d;
    logic fall;

    // Falling edge is the leading edge of a negative pulse and the trailing edge of a positive one
    // Masked until the chain is filled: an idle-low line would fake a zero after reset
    assign fall = (q.warm == uart_ext_pkg::IR_WARM_DONE) & q.prev & ~q.sync2;

    always_comb begin
        d       = q;
        d.sync1 = ir_rx_i;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        d.warm  = (q.warm == uart_ext_pkg::IR_WARM_DONE) ? q.warm : q.warm + 2'h1;
        // Edge seen in the tick cycle is kept, not lost
        d.pend  = fall | (q.pend & ~tick_i);
        if (tick_i) begin
            if (q.pend) begin
                d.int_rx = 1'b0;
                d.cnt    = 4'h0;
            end else if (!q.int_rx) begin
                if (q.cnt == uart_ext_pkg::IR_LAST_TICK) begin
                    d.int_rx = 1'b1;
                end else begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, pend: 1'b0, int_rx: 1'b1, cnt: 4'h0, warm: 2'h0};
        end else begin
            q <= d;
        end
    end

    assign int_rx_o = q.int_rx;

    chk_ir_zero_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tick_i && q.pend) |=> (!int_rx_o && q.cnt == 4'h0))
        else $error("decoded zero did not start on tick after edge");

    chk_ir_bit_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tick_i && !q.pend && !q.int_rx && q.cnt == 4'hF) |=> int_rx_o)
        else $error("decoded zero not ended after sixteen ticks");

    chk_ir_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(int_rx_o) |-> $past(q.pend))
        else $error("decoded zero without a preceding falling edge");
endmodule

// *** logic/uart_ext_regs.sv ***
// One channel's register bank with base and extended register decode, on APB.
// Assumes APB master on SYS_CLK_I; status inputs come from channel logic on the same clock.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module uart_ext_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic [7:0]        RX_DATA_I,
    input  wire logic [7:0]        INT_IDENT_I,
    input  wire logic [7:0]        LINE_STATUS_I,
    input  wire logic [7:0]        MODEM_STATUS_I,
    input  wire logic [7:0]        FIFO_READY_I,
    output logic      [7:0]        TX_DATA_O,
    output logic                   TX_WR_O,
    output logic                   RX_RD_O,
    output logic      [7:0]        FIFO_CTRL_O,
    output logic                   FIFO_CTRL_WR_O,
    output logic      [7:0]        IRQ_ENABLE_O,
    output logic      [7:0]        LINE_CTRL_O,
    output logic      [7:0]        MODEM_CTRL_O,
    output logic      [15:0]       DIVISOR_O,
    output logic      [7:0]        FEATURE_O,
    output logic      [7:0]        RESUME1_O,
    output logic      [7:0]        RESUME2_O,
    output logic      [7:0]        PAUSE1_O,
    output logic      [7:0]        PAUSE2_O,
    output logic      [7:0]        THRESHOLD_O,
    output logic      [7:0]        TRIGGER_O,
    input  wire logic              SAMPLE_TICK_I,
    input  wire logic              IR_RX_I,
    output logic                   INT_RX_O
);
    typedef enum logic [1:0] {
        SEL7_SCR   = 2'h0,
        SEL7_TLR   = 2'h1,
        SEL7_FRR   = 2'h2,
        SEL7_PAUSE_CHAR_SECOND = 2'h3
    } sel7_t;

    typedef struct packed {
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [7:0]  feat;
        logic [7:0]  line_control;
        logic [7:0]  modem_control;
        logic [7:0]  ier;
        logic [7:0]  scr;
        logic [7:0]  resume_char_first;
        logic [7:0]  resume_char_second;
        logic [7:0]  pause_char_first;
        logic [7:0]  pause_char_second;
        logic [7:0]  flow_threshold_control;
        logic [7:0]  fifo_trigger_levels;
        logic [7:0]  tx_data;
        logic [7:0]  fcr;
        logic        tx_wr;
        logic        rx_rd;
        logic        fcr_wr;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } regs_t;

    regs_t q, d;

    logic       addr_ok;
    logic [2:0] idx;
    logic       first_acc;
    logic       done;
    logic       wr_done;
    uart_ext_pkg::sel_t sel;
    sel7_t      sel7;

    // Offsets 0..6 share one decode; offset 7 has four candidates so it gets its own
    function automatic uart_ext_pkg::sel_t decode(input logic [2:0] i, input logic [7:0] line_control,
                                                  input logic [7:0] feat, input logic [7:0] modem_control);
        logic ext_key;
        logic div_on;
        logic thr_on;
        ext_key = (line_control == uart_ext_pkg::LCR_EXT_KEY);
        div_on  = line_control[uart_ext_pkg::LCR_DIV_BIT];
        thr_on  = !div_on && feat[uart_ext_pkg::FEAT_EXT_BIT] && modem_control[uart_ext_pkg::MCR_EXT_BIT];
        decode  = uart_ext_pkg::SEL_SCR;
        case (i)
            uart_ext_pkg::IDX_DATA: begin
                decode = div_on ? uart_ext_pkg::SEL_DIV_LO : uart_ext_pkg::SEL_DATA;
            end
            uart_ext_pkg::IDX_IER: begin
                decode = div_on ? uart_ext_pkg::SEL_DIV_HI : uart_ext_pkg::SEL_IER;
            end
            uart_ext_pkg::IDX_FEAT: begin
                decode = ext_key ? uart_ext_pkg::SEL_FEAT : uart_ext_pkg::SEL_IDENT;
            end
            uart_ext_pkg::IDX_LCR: begin
                decode = uart_ext_pkg::SEL_LCR;
            end
            uart_ext_pkg::IDX_MCR: begin
                decode = ext_key ? uart_ext_pkg::SEL_RESUME_CHAR_FIRST : uart_ext_pkg::SEL_MCR;
            end
            uart_ext_pkg::IDX_LSR: begin
                decode = ext_key ? uart_ext_pkg::SEL_RESUME_CHAR_SECOND : uart_ext_pkg::SEL_LSR;
            end
            uart_ext_pkg::IDX_MSR: begin
                if (ext_key) begin
                    decode = uart_ext_pkg::SEL_PAUSE_CHAR_FIRST;
                end else if (thr_on) begin
                    decode = uart_ext_pkg::SEL_TCR;
                end else begin
                    decode = uart_ext_pkg::SEL_MSR;
                end
            end
            default: begin
                decode = uart_ext_pkg::SEL_SCR;
            end
        endcase
    endfunction

    function automatic sel7_t decode7(input logic [7:0] line_control, input logic [7:0] feat, input logic [7:0] modem_control);
        decode7 = SEL7_SCR;
        if (line_control == uart_ext_pkg::LCR_EXT_KEY) begin
            decode7 = SEL7_PAUSE_CHAR_SECOND;
        end else if (line_control[uart_ext_pkg::LCR_DIV_BIT]) begin
            decode7 = SEL7_SCR;
        end else if (modem_control[uart_ext_pkg::MCR_EXT_BIT]) begin
            // Trigger levels need the feature bit too; without it the ready status shows
            decode7 = feat[uart_ext_pkg::FEAT_EXT_BIT] ? SEL7_TLR : SEL7_FRR;
        end else begin
            decode7 = SEL7_SCR;
        end
    endfunction

    assign idx       = PADDR_I[uart_ext_pkg::IDX_LSB+2:uart_ext_pkg::IDX_LSB];
    assign addr_ok   = (PADDR_I[1:0] == 2'h0) && ((PADDR_I >> (uart_ext_pkg::IDX_LSB + 3)) == '0);
    assign first_acc = PSEL_I && PENABLE_I && !q.ready;
    assign done      = PSEL_I && PENABLE_I && q.ready;
    assign wr_done   = done && PWRITE_I && addr_ok;
    assign sel       = decode(idx, q.line_control, q.feat, q.modem_control);
    assign sel7      = decode7(q.line_control, q.feat, q.modem_control);

    always_comb begin
        logic [7:0] rd;
        rd       = 8'h00;
        d        = q;
        d.tx_wr  = 1'b0;
        d.rx_rd  = 1'b0;
        d.fcr_wr = 1'b0;
        d.ready  = 1'b0;
        if (idx == uart_ext_pkg::IDX_SCR) begin
            case (sel7)
                SEL7_PAUSE_CHAR_SECOND: rd = q.pause_char_second;
                SEL7_TLR:   rd = q.fifo_trigger_levels;
                SEL7_FRR:   rd = FIFO_READY_I;
                default:    rd = q.scr;
            endcase
        end else begin
            case (sel)
                uart_ext_pkg::SEL_DATA:   rd = RX_DATA_I;
                uart_ext_pkg::SEL_IER:    rd = q.ier;
                uart_ext_pkg::SEL_IDENT:  rd = INT_IDENT_I;
                uart_ext_pkg::SEL_LCR:    rd = q.line_control;
                uart_ext_pkg::SEL_MCR:    rd = q.modem_control;
                uart_ext_pkg::SEL_LSR:    rd = LINE_STATUS_I;
                uart_ext_pkg::SEL_MSR:    rd = MODEM_STATUS_I;
                uart_ext_pkg::SEL_DIV_LO: rd = q.div_lo;
                uart_ext_pkg::SEL_DIV_HI: rd = q.div_hi;
                uart_ext_pkg::SEL_FEAT:   rd = q.feat;
                uart_ext_pkg::SEL_RESUME_CHAR_FIRST:   rd = q.resume_char_first;
                uart_ext_pkg::SEL_RESUME_CHAR_SECOND:   rd = q.resume_char_second;
                uart_ext_pkg::SEL_PAUSE_CHAR_FIRST:  rd = q.pause_char_first;
                uart_ext_pkg::SEL_TCR:    rd = q.flow_threshold_control;
                default:                  rd = q.scr;
            endcase
        end
        // Answer one cycle into the access phase; data and error are captured here
        if (first_acc) begin
            d.ready  = 1'b1;
            d.slverr = !addr_ok;
            d.rdata  = (PWRITE_I || !addr_ok) ? uart_ext_pkg::RST_WORD : {24'h000000, rd};
        end
        // Side effects of a data read happen only when the master takes the word
        if (done && !PWRITE_I && addr_ok && idx == uart_ext_pkg::IDX_DATA
            && sel == uart_ext_pkg::SEL_DATA) begin
            d.rx_rd = 1'b1;
        end
        if (wr_done) begin
            if (idx == uart_ext_pkg::IDX_SCR) begin
                case (sel7)
                    SEL7_PAUSE_CHAR_SECOND: d.pause_char_second = PWDATA_I[7:0];
                    SEL7_TLR:   d.fifo_trigger_levels   = PWDATA_I[7:0];
                    SEL7_FRR:   d.scr   = q.scr;
                    default:    d.scr   = PWDATA_I[7:0];
                endcase
            end else begin
                case (sel)
                    uart_ext_pkg::SEL_DATA: begin
                        d.tx_data = PWDATA_I[7:0];
                        d.tx_wr   = 1'b1;
                    end
                    uart_ext_pkg::SEL_IER:    d.ier    = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_IDENT: begin
                        d.fcr    = PWDATA_I[7:0];
                        d.fcr_wr = 1'b1;
                    end
                    uart_ext_pkg::SEL_LCR:    d.line_control    = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_MCR:    d.modem_control    = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_DIV_LO: d.div_lo = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_DIV_HI: d.div_hi = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_FEAT:   d.feat   = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_RESUME_CHAR_FIRST:   d.resume_char_first   = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_RESUME_CHAR_SECOND:   d.resume_char_second   = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_PAUSE_CHAR_FIRST:  d.pause_char_first  = PWDATA_I[7:0];
                    uart_ext_pkg::SEL_TCR:    d.flow_threshold_control    = PWDATA_I[7:0];
                    default:                  d.scr    = q.scr;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= '{div_lo: uart_ext_pkg::RST_BYTE, div_hi: uart_ext_pkg::RST_BYTE,
                   feat: uart_ext_pkg::RST_BYTE, line_control: uart_ext_pkg::RST_LCR,
                   modem_control: uart_ext_pkg::RST_BYTE, ier: uart_ext_pkg::RST_BYTE,
                   scr: uart_ext_pkg::RST_BYTE, resume_char_first: uart_ext_pkg::RST_BYTE,
                   resume_char_second: uart_ext_pkg::RST_BYTE, pause_char_first: uart_ext_pkg::RST_BYTE,
                   pause_char_second: uart_ext_pkg::RST_BYTE, flow_threshold_control: uart_ext_pkg::RST_BYTE,
                   fifo_trigger_levels: uart_ext_pkg::RST_BYTE, tx_data: uart_ext_pkg::RST_BYTE,
                   fcr: uart_ext_pkg::RST_BYTE, tx_wr: 1'b0, rx_rd: 1'b0, fcr_wr: 1'b0,
                   ready: 1'b0, slverr: 1'b0, rdata: uart_ext_pkg::RST_WORD};
        end else begin
            q <= d;
        end
    end

    assign PRDATA_O       = q.rdata;
    assign PREADY_O       = q.ready;
    assign PSLVERR_O      = q.slverr;
    assign TX_DATA_O      = q.tx_data;
    assign TX_WR_O        = q.tx_wr;
    assign RX_RD_O        = q.rx_rd;
    assign FIFO_CTRL_O    = q.fcr;
    assign FIFO_CTRL_WR_O = q.fcr_wr;
    assign IRQ_ENABLE_O   = q.ier;
    assign LINE_CTRL_O    = q.line_control;
    assign MODEM_CTRL_O   = q.modem_control;
    assign DIVISOR_O      = {q.div_hi, q.div_lo};
    assign FEATURE_O      = q.feat;
    assign RESUME1_O      = q.resume_char_first;
    assign RESUME2_O      = q.resume_char_second;
    assign PAUSE1_O       = q.pause_char_first;
    assign PAUSE2_O       = q.pause_char_second;
    assign THRESHOLD_O    = q.flow_threshold_control;
    assign TRIGGER_O      = q.fifo_trigger_levels;

    ir_rx_decoder u_ir_rx (
        .clk_i    (SYS_CLK_I),
        .rst_n_i  (RST_N_I),
        .tick_i   (SAMPLE_TICK_I),
        .ir_rx_i  (IR_RX_I),
        .int_rx_o (INT_RX_O)
    );

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_lcr_readback: assert property (
        (done && !PWRITE_I && PADDR_I == 8'h0C) |-> (PRDATA_O == {24'h000000, q.line_control}))
        else $error("line control read back differs");

    chk_div_low_map: assert property (
        (wr_done && PADDR_I == 8'h00 && q.line_control == 8'h80) |=> (DIVISOR_O[7:0] == $past(PWDATA_I[7:0]) && !TX_WR_O))
        else $error("divisor low byte not written under divisor access");

    chk_pause1_map: assert property (
        (wr_done && PADDR_I == 8'h18 && q.line_control == 8'hBF) |=> (PAUSE1_O == $past(PWDATA_I[7:0])))
        else $error("first pause character not written");

    chk_resume2_map: assert property (
        (wr_done && PADDR_I == 8'h14 && q.line_control == 8'hBF) |=> (RESUME2_O == $past(PWDATA_I[7:0])))
        else $error("second resume character not written");

    chk_feature_read: assert property (
        (done && !PWRITE_I && PADDR_I == 8'h08 && q.line_control == 8'hBF) |-> (PRDATA_O[7:0] == FEATURE_O))
        else $error("feature register read mismatch");

    chk_thresh_map: assert property (
        (wr_done && PADDR_I == 8'h18 && q.line_control == 8'h00 && q.feat[4] && q.modem_control[6])
        |=> (THRESHOLD_O == $past(PWDATA_I[7:0]) && PAUSE1_O == $past(PAUSE1_O)))
        else $error("threshold register not selected");

    chk_trigger_map: assert property (
        (wr_done && PADDR_I == 8'h1C && q.line_control == 8'h00 && q.feat[4] && q.modem_control[6])
        |=> (TRIGGER_O == $past(PWDATA_I[7:0])))
        else $error("trigger level register not selected");

    chk_ready_read: assert property (
        (first_acc && !PWRITE_I && PADDR_I == 8'h1C && q.line_control == 8'h00 && !q.feat[4] && q.modem_control[6])
        |=> (PRDATA_O[7:0] == $past(FIFO_READY_I)))
        else $error("ready status not returned");

    chk_base_data: assert property (
        (wr_done && PADDR_I == 8'h00 && !q.line_control[7]) |=> (TX_WR_O && TX_DATA_O == $past(PWDATA_I[7:0])))
        else $error("ordinary data write missing");

    chk_apb_answer: assert property (
        (PSEL_I && !PENABLE_I) ##1 (PSEL_I && PENABLE_I) |=> PREADY_O)
        else $error("access phase not answered in one cycle");

    chk_mcr_read: assert property (
        (done && !PWRITE_I && PADDR_I == 8'h10 && q.line_control != 8'hBF) |-> (PRDATA_O == {24'h000000, q.modem_control}))
        else $error("modem control read back differs");

    chk_rx_read_pulse: assert property (
        (done && !PWRITE_I && PADDR_I == 8'h00 && !q.line_control[7]) |=> RX_RD_O)
        else $error("data read pulse missing");
endmodule

// *** sim/apb_host_model.sv ***
// Host processor model: one APB master issuing single register transfers.
// Assumes the bench calls xfer one transfer at a time; the slave answers with pready.
`timescale 1ns/1ps
module apb_host_model (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o
);
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
    end

    // Request held unchanged until pready is sampled high; no wait limit here
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= addr;
        pwdata_o  <= {24'h000000, wd};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rd = prdata_i[7:0];
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

// *** sim/uart_ext_regs_tb.sv ***
// Self-checking bench for the channel register bank and infrared decoder.
// Assumes the host model for APB; answers are checked against queued notes.
`timescale 1ns/1ps
module uart_ext_regs_tb;
    localparam int         TICK_DIV    = 4;
    localparam logic [2:0] EXT_IDX [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    typedef struct packed {
        logic       chk;
        logic [7:0] data;
        logic       err;
    } note_t;
    logic        SYS_CLK_I     = 1'b0;
    logic        RST_N_I       = 1'b0;
    logic        SAMPLE_TICK_I = 1'b0;
    logic        IR_RX_I       = 1'b0;
    logic [1:0]  tick_cnt      = 2'h0;
    logic [7:0]  st [5]        = '{default: 8'h00};
    logic        psel, penable, pwrite, PREADY_O, PSLVERR_O, INT_RX_O, TX_WR_O, RX_RD_O, FIFO_CTRL_WR_O;
    logic [7:0]  FIFO_CTRL_O, IRQ_ENABLE_O, LINE_CTRL_O, MODEM_CTRL_O;
    int          n_tx = 0, n_rx = 0, n_fc = 0;
    logic [7:0]  paddr, TX_DATA_O, FEATURE_O, RESUME1_O, RESUME2_O, PAUSE1_O, PAUSE2_O, THRESHOLD_O, TRIGGER_O;
    logic [15:0] DIVISOR_O;
    logic [31:0] pwdata, PRDATA_O;
    note_t       notes [$];
    note_t       cur;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          n;
    logic [7:0]  v [5];
    logic [7:0]  t1, t2, t3, rd;

    uart_ext_regs uart_ext_regs_i (
        .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
        .RX_DATA_I(st[0]), .INT_IDENT_I(st[1]), .LINE_STATUS_I(st[2]), .MODEM_STATUS_I(st[3]),
        .FIFO_READY_I(st[4]), .TX_DATA_O(TX_DATA_O), .TX_WR_O(TX_WR_O), .RX_RD_O(RX_RD_O),
        .FIFO_CTRL_O(FIFO_CTRL_O), .FIFO_CTRL_WR_O(FIFO_CTRL_WR_O), .IRQ_ENABLE_O(IRQ_ENABLE_O),
        .LINE_CTRL_O(LINE_CTRL_O), .MODEM_CTRL_O(MODEM_CTRL_O), .DIVISOR_O(DIVISOR_O),
        .FEATURE_O(FEATURE_O), .RESUME1_O(RESUME1_O), .RESUME2_O(RESUME2_O), .PAUSE1_O(PAUSE1_O),
        .PAUSE2_O(PAUSE2_O), .THRESHOLD_O(THRESHOLD_O), .TRIGGER_O(TRIGGER_O),
        .SAMPLE_TICK_I(SAMPLE_TICK_I), .IR_RX_I(IR_RX_I), .INT_RX_O(INT_RX_O));
    apb_host_model apb_host_model_i (.clk_i(SYS_CLK_I), .pready_i(PREADY_O), .prdata_i(PRDATA_O),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

    always #5 SYS_CLK_I = ~SYS_CLK_I;

    // Side-effect pulses are counted and checked once at the end
    always @(posedge SYS_CLK_I) begin
        if (TX_WR_O === 1'b1) n_tx++;
        if (RX_RD_O === 1'b1) n_rx++;
        if (FIFO_CTRL_WR_O === 1'b1) n_fc++;
    end

    // Fast sampling tick keeps the infrared run short
    always @(posedge SYS_CLK_I) begin
        tick_cnt      <= tick_cnt + 2'h1;
        SAMPLE_TICK_I <= (tick_cnt == 2'(TICK_DIV - 1));
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    always @(posedge SYS_CLK_I) begin
        if (PREADY_O === 1'b1) begin
            if (notes.size() == 0) begin
                cmp1(1'b1, 1'b0, "answer without request");
            end else begin
                cur = notes.pop_front();
                cmp1(PSLVERR_O, cur.err, "slave error");
                cmp8(PRDATA_O[31:24] | PRDATA_O[23:16] | PRDATA_O[15:8], 8'h00, "read upper bits");
                if (cur.chk) cmp8(PRDATA_O[7:0], cur.data, "read data");
            end
        end
    end

    task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd, input note_t nt,
                       output logic [7:0] r);
        notes.push_back(nt);
        apb_host_model_i.xfer(wr, addr, wd, r);
    endtask

    task automatic reg_wr(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] r;
        acc(1'b1, {3'h0, idx, 2'h0}, d, '{1'b0, 8'h00, 1'b0}, r);
    endtask

    task automatic reg_rd(input logic [2:0] idx, input logic [7:0] e);
        logic [7:0] r;
        acc(1'b0, {3'h0, idx, 2'h0}, 8'h00, '{1'b1, e, 1'b0}, r);
    endtask

    task automatic reg_get(input logic [2:0] idx, output logic [7:0] r);
        acc(1'b0, {3'h0, idx, 2'h0}, 8'h00, '{1'b0, 8'h00, 1'b0}, r);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        void'($urandom(32'h7AB2DF2D));
        repeat (6) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        foreach (st[i]) st[i] <= 8'($urandom);
        foreach (v[i]) v[i] = 8'($urandom);
        v[0][4] = 1'b0;
        reg_rd(3'h3, 8'h00);
        reg_wr(3'h3, v[1] & 8'h7F);
        reg_rd(3'h3, v[1] & 8'h7F);
        reg_rd(3'h0, st[0]);
        reg_rd(3'h2, st[1]);
        reg_rd(3'h5, st[2]);
        reg_rd(3'h6, st[3]);
        cmp1(INT_RX_O, 1'b1, "zero after reset");
        reg_wr(3'h3, 8'h80);
        reg_wr(3'h0, v[2]);
        reg_wr(3'h1, v[3]);
        reg_rd(3'h0, v[2]);
        reg_rd(3'h1, v[3]);
        cmp8(DIVISOR_O[7:0], v[2], "divisor low");
        cmp8(DIVISOR_O[15:8], v[3], "divisor high");
        reg_wr(3'h3, 8'hBF);
        foreach (v[i]) reg_wr(EXT_IDX[i], v[i]);
        foreach (v[i]) reg_rd(EXT_IDX[i], v[i]);
        cmp8(FEATURE_O, v[0], "feature");
        cmp8(RESUME1_O, v[1], "resume one");
        cmp8(RESUME2_O, v[2], "resume two");
        cmp8(PAUSE1_O, v[3], "pause one");
        cmp8(PAUSE2_O, v[4], "pause two");
        reg_wr(3'h3, 8'h00);
        reg_wr(3'h0, v[4]);
        reg_get(3'h4, t3);
        reg_wr(3'h4, t3 | 8'h40);
        cmp8(TX_DATA_O, v[4], "transmit byte");
        reg_rd(3'h4, t3 | 8'h40);
        reg_rd(3'h7, st[4]);
        reg_wr(3'h4, t3);
        reg_get(3'h3, t1);
        reg_wr(3'h3, 8'hBF);
        reg_get(3'h2, t2);
        reg_wr(3'h2, t2 | 8'h10);
        reg_wr(3'h3, 8'h00);
        reg_get(3'h4, t3);
        reg_wr(3'h4, t3 | 8'h40);
        reg_wr(3'h6, ~v[0]);
        reg_wr(3'h7, ~v[1]);
        reg_rd(3'h6, ~v[0]);
        reg_rd(3'h7, ~v[1]);
        cmp8(THRESHOLD_O, ~v[0], "threshold");
        cmp8(TRIGGER_O, ~v[1], "trigger");
        reg_wr(3'h3, 8'hBF);
        reg_wr(3'h2, t2);
        reg_wr(3'h3, t1);
        reg_wr(3'h4, t3);
        reg_rd(3'h6, st[3]);
        cmp8(LINE_CTRL_O, t1, "line control restored");
        cmp8(MODEM_CTRL_O, t3, "modem control restored");
        cmp8(FEATURE_O, t2, "feature restored");
        reg_wr(3'h1, v[4]);
        reg_wr(3'h2, v[3]);
        reg_wr(3'h7, v[2]);
        reg_rd(3'h1, v[4]);
        reg_rd(3'h7, v[2]);
        cmp8(IRQ_ENABLE_O, v[4], "irq enable");
        cmp8(FIFO_CTRL_O, v[3], "fifo control");
        acc(1'b0, 8'h0D, 8'h00, '{1'b1, 8'h00, 1'b1}, rd);
        acc(1'b1, 8'h20, 8'h5A, '{1'b0, 8'h00, 1'b1}, rd);
        // Positive pulse: line idles low, zero expected only after it ends
        IR_RX_I <= 1'b1;
        repeat (3 * TICK_DIV) @(posedge SYS_CLK_I);
        cmp1(INT_RX_O, 1'b1, "zero before pulse end");
        IR_RX_I <= 1'b0;
        n = 0;
        while (INT_RX_O !== 1'b0 && n < 40) begin
            @(posedge SYS_CLK_I);
            n++;
        end
        cmp1(INT_RX_O, 1'b0, "zero after trailing edge");
        n = 0;
        while (INT_RX_O === 1'b0 && n < 200) begin
            @(posedge SYS_CLK_I);
            n++;
        end
        cmp8(8'(n), 8'(16 * TICK_DIV), "zero length");
        cmp8(8'(n_tx), 8'h01, "data write pulses");
        cmp8(8'(n_rx), 8'h01, "data read pulses");
        cmp8(8'(n_fc), 8'h01, "fifo control pulses");
        end_sim();
    end
endmodule
